// ==== cpsp_status_page.sv ====
// Cable port status page with Avalon-MM slave and interrupt
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cpsp_status_page #(
    parameter int NPORT = cpsp_pkg::NUM_PORTS
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST,
    // Avalon-MM slave
    input wire logic [cpsp_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [cpsp_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [cpsp_pkg::DATA_W-1:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Per-port line and link state from the port logic
    input wire logic [2*NPORT-1:0] I_PAIR_A_LINE_STATE,
    input wire logic [2*NPORT-1:0] I_PAIR_B_LINE_STATE,
    input wire logic [NPORT-1:0] I_CHILD,
    input wire logic [NPORT-1:0] I_CONNECTED,
    input wire logic [NPORT-1:0] I_BIAS,
    input wire logic [3*NPORT-1:0] I_NEGOTIATED_SPEED,
    input wire logic [NPORT-1:0] I_SUSPEND_FAULT,
    // Controls back to the ports
    output logic [NPORT-1:0] O_PORT_DISABLE,
    output logic O_PORT_EVENT,
    output logic O_IRQ
);
    import cpsp_pkg::*;

    cpsp_top_state_type r; // Registered state
    cpsp_top_state_type next_r; // Next state

    // Per-port views
    logic [7:0] line_reg [NPORT]; // Line byte per port
    logic [7:0] ctrl_reg [NPORT]; // Control byte per port
    logic [NPORT-1:0] wr_line; // Line byte write strobes
    logic [NPORT-1:0] wr_ctrl; // Control byte write strobes
    logic [NPORT-1:0] fault_set; // Fault raised pulses
    logic [NPORT-1:0] port_event; // Enabled field changes

    // Bus side helpers
    logic access; // Request completes this edge
    logic wr_low; // Write touching the low lane
    logic [IRQ_W-1:0] irq_set; // Events this cycle
    logic [IRQ_W-1:0] irq_clr; // Write-one-to-clear mask

    // Register index from byte address; unmapped gives zero
    function automatic logic [2:0] reg_index(
        input logic [ADDR_W-1:0] addr
    );
        logic [2:0] idx;
        idx = 3'h0;
        case (addr)
            OFS_PORT_SELECT: begin
                idx = 3'h1;
            end
            OFS_LINE_STATE: begin
                idx = 3'h2;
            end
            OFS_SPEED_EVENT: begin
                idx = 3'h3;
            end
            OFS_IRQ_STATUS: begin
                idx = 3'h4;
            end
            OFS_IRQ_MASK: begin
                idx = 3'h5;
            end
            default: begin
                idx = 3'h0;
            end
        endcase
        return idx;
    endfunction : reg_index

    // One unit per cable port, each with its own copy
    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++) begin : g_port
            cpsp_port_unit u_port (
                .i_clk(I_MCLK),
                .i_rst(I_RST),
                .i_pair_a_line_state(I_PAIR_A_LINE_STATE[2*gi +: 2]),
                .i_pair_b_line_state(I_PAIR_B_LINE_STATE[2*gi +: 2]),
                .i_child(I_CHILD[gi]),
                .i_connected(I_CONNECTED[gi]),
                .i_bias(I_BIAS[gi]),
                .i_speed(I_NEGOTIATED_SPEED[3*gi +: 3]),
                .i_suspend_fault(I_SUSPEND_FAULT[gi]),
                .i_wr_line(wr_line[gi]),
                .i_wr_ctrl(wr_ctrl[gi]),
                .i_wdata(I_AVS_WRITEDATA[7:0]),
                .o_line_reg(line_reg[gi]),
                .o_ctrl_reg(ctrl_reg[gi]),
                .o_disabled(O_PORT_DISABLE[gi]),
                .o_fault_set(fault_set[gi]),
                .o_event(port_event[gi])
            );
            // Page writes reach only the selected port
            assign wr_line[gi] = wr_low && (r.sel == SEL_W'(gi))
                && (reg_index(I_AVS_ADDRESS) == 3'h2);
            assign wr_ctrl[gi] = wr_low && (r.sel == SEL_W'(gi))
                && (reg_index(I_AVS_ADDRESS) == 3'h3);
        end
    endgenerate

    // A request is taken on the edge where waitrequest is low
    assign access = (I_AVS_READ | I_AVS_WRITE) && (r.bus == BUS_ACK);
    // Only byte lane 0 carries register bits
    assign wr_low = access && I_AVS_WRITE && I_AVS_BYTEENABLE[0];

    // Interrupt events and clears
    always_comb begin
        irq_set = '0;
        irq_clr = '0;
        // Any enabled port change raises the global flag
        irq_set[IRQ_PORT_BIT] = |port_event;
        irq_set[IRQ_FAULT_BIT] = |fault_set;
        // Write one to clear
        if (wr_low && (reg_index(I_AVS_ADDRESS) == 3'h4)) begin
            irq_clr = I_AVS_WRITEDATA[IRQ_W-1:0];
        end
    end

    // Next-state logic for the bus slave and shared registers
    always_comb begin
        next_r = r;
        case (r.bus)
            // Wait one cycle, then answer with data ready
            BUS_IDLE: begin
                if (I_AVS_READ | I_AVS_WRITE) begin
                    next_r.bus = BUS_ACK;
                    next_r.wait_req = 1'b0;
                    // Read data sampled here, held in the answer cycle
                    case (reg_index(I_AVS_ADDRESS))
                        3'h1: begin
                            next_r.rdata = 8'h00;
                            next_r.rdata[SEL_W-1:0] = r.sel;
                        end
                        3'h2: begin
                            // Fields of the selected port only
                            next_r.rdata = line_reg[r.sel];
                        end
                        3'h3: begin
                            next_r.rdata = ctrl_reg[r.sel];
                        end
                        3'h4: begin
                            next_r.rdata = 8'h00;
                            next_r.rdata[IRQ_W-1:0] = r.irq_status;
                        end
                        3'h5: begin
                            next_r.rdata = 8'h00;
                            next_r.rdata[IRQ_W-1:0] = r.irq_mask;
                        end
                        default: begin
                            // Unmapped reads return zero
                            next_r.rdata = 8'h00;
                        end
                    endcase
                end
            end
            // Request completes; return to waiting
            BUS_ACK: begin
                next_r.bus = BUS_IDLE;
                next_r.wait_req = 1'b1;
            end
            default: begin
                next_r.bus = BUS_IDLE;
                next_r.wait_req = 1'b1;
            end
        endcase
        // Port select and mask writes
        if (wr_low && (reg_index(I_AVS_ADDRESS) == 3'h1)) begin
            next_r.sel = I_AVS_WRITEDATA[SEL_W-1:0];
        end
        if (wr_low && (reg_index(I_AVS_ADDRESS) == 3'h5)) begin
            next_r.irq_mask = I_AVS_WRITEDATA[IRQ_W-1:0];
        end
        // Set wins over a same-cycle clear
        next_r.irq_status = (r.irq_status & ~irq_clr) | irq_set;
        // Level interrupt from unmasked status
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    end

    // State register, synchronous reset
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            r <= TOP_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign O_AVS_READDATA = {24'h0000_00, r.rdata};
    assign O_AVS_WAITREQUEST = r.wait_req;
    assign O_PORT_EVENT = r.irq_status[IRQ_PORT_BIT];
    assign O_IRQ = r.irq;
endmodule : cpsp_status_page
`default_nettype wire

// ==== cpsp_pkg.sv ====
// Constants and types for the cable port status page
`default_nettype none
package cpsp_pkg;
    // Number of cable ports
    localparam int NUM_PORTS = 2;
    // Port select width
    localparam int SEL_W = 1;
    // Avalon byte address width and data width
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PORT_SELECT = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_LINE_STATE = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_SPEED_EVENT = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;
    // Field positions in port_line_and_link_state
    localparam int LINE_A_POS = 6;
    localparam int LINE_B_POS = 4;
    localparam int LINE_CHILD_BIT = 3;
    localparam int LINE_CONN_BIT = 2;
    localparam int LINE_BIAS_BIT = 1;
    localparam int LINE_DIS_BIT = 0;
    // Field positions in port_speed_and_event_control
    localparam int CTRL_SPEED_POS = 5;
    localparam int CTRL_INTEN_BIT = 4;
    localparam int CTRL_FAULT_BIT = 3;
    // Interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_PORT_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
    // Line state codes
    localparam logic [1:0] LINE_INVALID = 2'h0;
    localparam logic [1:0] LINE_ONE = 2'h1;
    localparam logic [1:0] LINE_ZERO = 2'h2;
    localparam logic [1:0] LINE_HIGH_Z = 2'h3;
    // Bus handshake states
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } cpsp_bus_state_type;
    // Per-port state
    typedef struct packed {
        logic [1:0] pair_a_line_state;
        logic [1:0] pair_b_line_state;
        logic child;
        logic connected;
        logic bias;
        logic disabled;
        logic [2:0] speed;
        logic int_enable;
        logic fault;
        logic fault_set;
        logic event_pulse;
    } cpsp_port_state_type;
    localparam cpsp_port_state_type PORT_RESET = '0;
    // Top-level state
    typedef struct packed {
        cpsp_bus_state_type bus;
        logic wait_req;
        logic [7:0] rdata;
        logic [SEL_W-1:0] sel;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
    } cpsp_top_state_type;
    localparam cpsp_top_state_type TOP_RESET = '{
        bus: BUS_IDLE, wait_req: 1'b1, rdata: 8'h00, sel: '0,
        irq_status: '0, irq_mask: '0, irq: 1'b0};
endpackage : cpsp_pkg
`default_nettype wire

// ==== cpsp_port_unit.sv ====
// One cable port's copy of the status page fields
`timescale 1ns/1ns
`default_nettype none
module cpsp_port_unit (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_pair_a_line_state,
    input wire logic [1:0] i_pair_b_line_state,
    input wire logic i_child,
    input wire logic i_connected,
    input wire logic i_bias,
    input wire logic [2:0] i_speed,
    input wire logic i_suspend_fault,
    input wire logic i_wr_line,
    input wire logic i_wr_ctrl,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_line_reg,
    output logic [7:0] o_ctrl_reg,
    output logic o_disabled,
    output logic o_fault_set,
    output logic o_event
);
    import cpsp_pkg::*;

    cpsp_port_state_type r; // Registered state
    cpsp_port_state_type next_r; // Next state
    logic changed; // Any watched field moves

    // Next-state logic
    always_comb begin
        next_r = r;
        changed = 1'b0;
        // Live line and link sampling, zero after reset
        next_r.pair_a_line_state = i_pair_a_line_state;
        next_r.pair_b_line_state = i_pair_b_line_state;
        // Value is meaningless in the tree-id window; passed as is
        next_r.child = i_child;
        next_r.connected = i_connected;
        next_r.bias = i_bias;
        next_r.speed = i_speed;
        // Software disable
        if (i_wr_line) begin
            next_r.disabled = i_wdata[LINE_DIS_BIT];
        end
        // Enable and fault clear
        if (i_wr_ctrl) begin
            next_r.int_enable = i_wdata[CTRL_INTEN_BIT];
            if (i_wdata[CTRL_FAULT_BIT]) begin
                next_r.fault = 1'b0;
            end
        end
        // Set beats a clear in the same cycle
        if (i_suspend_fault) begin
            next_r.fault = 1'b1;
        end
        next_r.fault_set = i_suspend_fault & ~r.fault;
        // Watch connection, bias, disable and fault
        changed = (next_r.connected != r.connected) | (next_r.bias != r.bias)
            | (next_r.disabled != r.disabled) | (next_r.fault != r.fault);
        next_r.event_pulse = r.int_enable & changed;
    end

    // State register, synchronous reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= PORT_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Byte images for readback
    assign o_line_reg = {r.pair_a_line_state, r.pair_b_line_state, r.child,
        r.connected, r.bias, r.disabled};
    assign o_ctrl_reg = {r.speed, r.int_enable, r.fault, 3'h0};
    assign o_disabled = r.disabled;
    assign o_fault_set = r.fault_set;
    assign o_event = r.event_pulse;
endmodule : cpsp_port_unit
`default_nettype wire

// ==== cpsp_status_page_props.sv ====
// Concurrent checks on the status page bus, disable and interrupt ports
`timescale 1ns/1ns
`default_nettype none
module cpsp_status_page_props #(
    parameter int NPORT = cpsp_pkg::NUM_PORTS
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic [cpsp_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [cpsp_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire logic [cpsp_pkg::DATA_W-1:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic [2*NPORT-1:0] I_PAIR_A_LINE_STATE,
    input wire logic [2*NPORT-1:0] I_PAIR_B_LINE_STATE,
    input wire logic [NPORT-1:0] I_CHILD,
    input wire logic [NPORT-1:0] I_CONNECTED,
    input wire logic [NPORT-1:0] I_BIAS,
    input wire logic [3*NPORT-1:0] I_NEGOTIATED_SPEED,
    input wire logic [NPORT-1:0] I_SUSPEND_FAULT,
    input wire logic [NPORT-1:0] O_PORT_DISABLE,
    input wire logic O_PORT_EVENT,
    input wire logic O_IRQ
);
    import cpsp_pkg::*;
    logic acc; // Access completing at this edge
    logic sel; // Shadow of the port select
    assign acc = (I_AVS_READ || I_AVS_WRITE) && !O_AVS_WAITREQUEST;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    // Follow the select so page reads can be tied to the right port
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            sel <= 1'b0;
        end else if (acc && I_AVS_WRITE && I_AVS_ADDRESS == OFS_PORT_SELECT && I_AVS_BYTEENABLE[0]) begin
            sel <= I_AVS_WRITEDATA[0];
        end
    end
    a_wait_answer: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("request not answered after one wait cycle");
    a_wait_single: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait: assert property (!(I_AVS_READ || I_AVS_WRITE) |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low without a request");
    a_upper_zero: assert property (O_AVS_READDATA[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    a_disable_write: assert property (acc && I_AVS_WRITE && I_AVS_ADDRESS == OFS_LINE_STATE && I_AVS_BYTEENABLE[0]
        |=> O_PORT_DISABLE[sel] == $past(I_AVS_WRITEDATA[0]))
        else $error("disable bit not taken from write");
    a_disable_hold: assert property (!(acc && I_AVS_WRITE && I_AVS_ADDRESS == OFS_LINE_STATE)
        |=> $stable(O_PORT_DISABLE))
        else $error("disable changed without a write");
    a_line_read: assert property (acc && I_AVS_READ && I_AVS_ADDRESS == OFS_LINE_STATE
        |-> O_AVS_READDATA[3:1] == $past({I_CHILD[sel], I_CONNECTED[sel], I_BIAS[sel]}, 2))
        else $error("role, connection or bias bit wrong");
    // Pair states two edges old: port register, then read data register
    a_pair_read: assert property (acc && I_AVS_READ && I_AVS_ADDRESS == OFS_LINE_STATE
        |-> O_AVS_READDATA[7:4] == $past({I_PAIR_A_LINE_STATE[2*sel+:2], I_PAIR_B_LINE_STATE[2*sel+:2]}, 2))
        else $error("pair line state field wrong");
    a_speed_read: assert property (acc && I_AVS_READ && I_AVS_ADDRESS == OFS_SPEED_EVENT
        |-> O_AVS_READDATA[7:5] == $past(I_NEGOTIATED_SPEED[3*sel+:3], 2))
        else $error("negotiated speed field wrong");
    a_unmapped_zero: assert property (acc && I_AVS_READ && I_AVS_ADDRESS > OFS_IRQ_MASK
        |-> O_AVS_READDATA == 32'h0000_0000)
        else $error("unmapped address read not zero");
    a_irq_clear: assert property ($fell(O_IRQ) |-> $past(acc && I_AVS_WRITE) || $past(acc && I_AVS_WRITE, 2))
        else $error("interrupt dropped without a write");
endmodule : cpsp_status_page_props
bind cpsp_status_page cpsp_status_page_props #(.NPORT(NPORT)) cpsp_status_page_props_inst (.*);
`default_nettype wire

// ==== cpsp_llc_model.sv ====
// Link controller model: Avalon-MM master for page accesses
`timescale 1ns/1ns
`default_nettype none
module cpsp_llc_model (
    input wire logic i_clk,
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest,
    output logic [cpsp_pkg::ADDR_W-1:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable
);
    import cpsp_pkg::*;
    // Idle bus from time zero
    initial begin
        o_address = 5'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0000_0000;
        o_byteenable = 4'hF;
    end
    // One access, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] b,
        output logic [31:0] q);
        @(posedge i_clk);
        o_address <= a;
        o_read <= ~w;
        o_write <= w;
        o_writedata <= {24'h00_0000, d};
        o_byteenable <= b;
        // No cycle limit here: only the bench's own timeout ends a hung wait
        do begin
            @(posedge i_clk);
        end while (i_waitrequest !== 1'b0);
        q = i_readdata;
        // Released lines flip so stale values never look valid
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_address <= ~a;
        o_writedata <= ~o_writedata;
    endtask : xfer
endmodule : cpsp_llc_model
`default_nettype wire

// ==== cable_port_status_page_tb.sv ====
// Random and corner-case bench for the cable port status page
`timescale 1ns/1ns
`default_nettype none
module cable_port_status_page_tb;
    import cpsp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd, wr, wreq, ev, irq, p;
    logic [4:0] addr;
    logic [3:0] be, pa = 4'h0, pb = 4'h0;
    logic [31:0] wdata, rdata, r, q, seed = 32'h0000_0024;
    logic [1:0] ch = 2'h0, cn = 2'h0, bs = 2'h0, sf = 2'h0, dis, dm = 2'h0;
    logic [5:0] spd = 6'h00;
    int miscompares = 0, comparisons = 0, cycles = 0;
    always #50 clk = ~clk;
    cpsp_status_page cpsp_status_page_inst (.I_MCLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wreq), .I_PAIR_A_LINE_STATE(pa), .I_PAIR_B_LINE_STATE(pb), .I_CHILD(ch),
        .I_CONNECTED(cn), .I_BIAS(bs), .I_NEGOTIATED_SPEED(spd), .I_SUSPEND_FAULT(sf),
        .O_PORT_DISABLE(dis), .O_PORT_EVENT(ev), .O_IRQ(irq));
    cpsp_llc_model cpsp_llc_model_inst (.i_clk(clk), .i_readdata(rdata), .i_waitrequest(wreq),
        .o_address(addr), .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be));
    // Xorshift source, fixed start
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Expected line and link byte of one port
    function automatic logic [31:0] line_exp(input logic k);
        return {24'h00_0000, pa[2*k+:2], pb[2*k+:2], ch[k], cn[k], bs[k], dm[k]};
    endfunction : line_exp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        cpsp_llc_model_inst.xfer(1'b1, a, d, 4'hF, q);
    endtask : wr_reg
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        cpsp_llc_model_inst.xfer(1'b0, a, 8'h00, 4'hF, q);
        check(q, exp);
    endtask : rd_chk
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Reset values on both pages and an unmapped hole
        for (int k = 0; k < 2; k++) begin
            wr_reg(OFS_PORT_SELECT, k[7:0]);
            rd_chk(OFS_LINE_STATE, 32'h0000_0000);
            rd_chk(OFS_SPEED_EVENT, 32'h0000_0000);
        end
        // Lane 0 off: the disable write must be ignored
        cpsp_llc_model_inst.xfer(1'b1, OFS_LINE_STATE, 8'h01, 4'hE, q);
        @(negedge clk);
        check(dis, dm);
        rd_chk(OFS_LINE_STATE, 32'h0000_0000);
        rd_chk(5'h14, 32'h0000_0000);
        $display("test reset values done");
        // Random line states; port 0 walks every pair A code
        for (int i = 0; i < 32; i++) begin
            r = xs();
            @(posedge clk);
            pa <= {r[1:0], i[1:0]};
            pb <= r[5:2];
            ch <= r[7:6];
            cn <= r[9:8];
            bs <= r[11:10];
            spd <= r[17:12];
            p = r[18];
            dm[p] = r[19];
            repeat (2 + r[21:20]) @(posedge clk);
            wr_reg(OFS_PORT_SELECT, {7'h00, p});
            wr_reg(OFS_LINE_STATE, {7'h00, r[19]});
            @(negedge clk);
            check(dis, dm);
            rd_chk(OFS_LINE_STATE, line_exp(p));
            rd_chk(OFS_SPEED_EVENT, {24'h00_0000, spd[3*p+:3], 5'h00});
        end
        $display("test random pages done");
        // Port event with the interrupt unmasked, then masked
        wr_reg(OFS_PORT_SELECT, 8'h00);
        wr_reg(OFS_SPEED_EVENT, 8'h10);
        wr_reg(OFS_IRQ_MASK, 8'h03);
        @(posedge clk);
        cn[0] <= ~cn[0];
        repeat (4) @(negedge clk);
        check({ev, irq}, 2'h3);
        rd_chk(OFS_IRQ_STATUS, 32'h0000_0001);
        wr_reg(OFS_IRQ_STATUS, 8'h01);
        repeat (2) @(negedge clk);
        check({ev, irq}, 2'h0);
        wr_reg(OFS_IRQ_MASK, 8'h00);
        @(posedge clk);
        bs[0] <= ~bs[0];
        repeat (4) @(negedge clk);
        check({ev, irq}, 2'h2);
        wr_reg(OFS_IRQ_STATUS, 8'h01);
        $display("test port event done");
        // Suspend fault on port 1, then cleared by writing one
        wr_reg(OFS_IRQ_MASK, 8'h02);
        wr_reg(OFS_PORT_SELECT, 8'h01);
        @(posedge clk);
        sf <= 2'h2;
        @(posedge clk);
        sf <= 2'h0;
        repeat (3) @(posedge clk);
        rd_chk(OFS_SPEED_EVENT, {24'h00_0000, spd[5:3], 5'h08});
        rd_chk(OFS_IRQ_STATUS, 32'h0000_0002);
        @(negedge clk);
        check(irq, 1'h1);
        wr_reg(OFS_SPEED_EVENT, 8'h08);
        wr_reg(OFS_IRQ_STATUS, 8'h02);
        rd_chk(OFS_SPEED_EVENT, {24'h00_0000, spd[5:3], 5'h00});
        rd_chk(OFS_IRQ_STATUS, 32'h0000_0000);
        $display("test suspend fault done");
        summarize();
    end
endmodule : cable_port_status_page_tb
`default_nettype wire
